// ---- rdf_pkg.sv ----
// Constants, types and helpers shared by the receive DC-free decoder
`default_nettype none
package rdf_pkg;
  // Register offsets on the register port
  localparam logic [6:0] RDF_OFS_FIFO = 7'h00;
  localparam logic [6:0] RDF_OFS_RATE_HI = 7'h03;
  localparam logic [6:0] RDF_OFS_RATE_LO = 7'h04;
  localparam logic [6:0] RDF_OFS_PKT1 = 7'h37;
  // Values after reset
  localparam logic [7:0] RDF_RST_RATE_HI = 8'h1a;
  localparam logic [7:0] RDF_RST_RATE_LO = 8'h0b;
  localparam logic [7:0] RDF_RST_PKT1 = 8'h10;
  // Line code select field position inside packet_settings_one
  localparam int RDF_LCS_LSB = 5;
  localparam logic [1:0] RDF_LCS_NONE = 2'h0;
  localparam logic [1:0] RDF_LCS_MANCH = 2'h1;
  localparam logic [1:0] RDF_LCS_WHITEN = 2'h2;
  // Data processing mode value that means packet mode
  localparam logic [1:0] RDF_DMODE_PACKET = 2'h0;
  // Whitening register preset and last bit index of a byte
  localparam logic [8:0] RDF_LFSR_PRESET = 9'h1ff;
  localparam logic [2:0] RDF_BIT_LAST = 3'h7;

  // Effective treatment of payload chips
  typedef enum logic [1:0] {RDF_PASS, RDF_MANCH, RDF_WHITEN} rdf_mode_e;

  // Software configuration carried as one bundle
  typedef struct packed {
    logic [15:0] divisor;
    logic [1:0] line_code_select;
  } rdf_cfg_s;

  // Decode select field and data mode into the payload treatment
  function automatic rdf_mode_e rdf_decode(input logic [1:0] sel, input logic [1:0] dmode);
    rdf_mode_e m;
    m = RDF_PASS;
    if (sel == RDF_LCS_MANCH && dmode == RDF_DMODE_PACKET) begin
      m = RDF_MANCH;
    end else if (sel == RDF_LCS_WHITEN) begin
      m = RDF_WHITEN;
    end
    return m;
  endfunction
endpackage
`default_nettype wire

// ---- rdf_whiten_lfsr.sv ----
// Nine-bit whitening sequence generator for the decoder
`timescale 1ns/1ns
`default_nettype none
module rdf_whiten_lfsr import rdf_pkg::*; #(
  parameter int WIDTH = 9
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Control
  input wire logic preset,
  input wire logic step,
  // Sequence
  output logic seq_bit,
  output logic [WIDTH-1:0] state
);
  logic [WIDTH-1:0] lfsr_r; // Shift register, bit 0 is the current mask bit

  // Preset wins over a step so a new packet always starts from all ones
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      lfsr_r <= RDF_LFSR_PRESET;
    end else if (preset) begin
      lfsr_r <= RDF_LFSR_PRESET;
    end else if (step) begin
      lfsr_r <= {lfsr_r[0] ^ lfsr_r[5], lfsr_r[WIDTH-1:1]};
    end
  end

  assign seq_bit = lfsr_r[0];
  assign state = lfsr_r;
endmodule
`default_nettype wire

// ---- rdf_rx_dc_free_decoder.sv ----
// Receive DC-free decoder: Manchester, de-whitening or pass, byte packing
`timescale 1ns/1ns
`default_nettype none
module rdf_rx_dc_free_decoder import rdf_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Register port
  input wire logic [6:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Mode from the data modulation setting
  input wire logic [1:0] data_mode,
  // Chip stream from the bit synchroniser and packet framing
  input wire logic chip_in,
  input wire logic sync_match,
  input wire logic frame_end,
  // Chip timing and preamble/sync NRZ stream
  output logic chip_tick,
  output logic nrz_valid,
  output logic nrz_bit,
  // Decoded bytes towards the receive FIFO
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic manch_error
);
  logic [7:0] rate_hi_r; // rate_divisor_high
  logic [7:0] rate_lo_r; // rate_divisor_low
  logic [7:0] pkt1_r; // packet_settings_one
  logic [7:0] reg_rdata_r; // Read data flop
  rdf_cfg_s cfg; // Configuration bundle
  rdf_mode_e mode; // Current payload treatment
  logic [15:0] div_cnt_r; // Chip period counter
  logic [15:0] div_last; // Terminal count of the chip period
  logic tick; // One cycle per chip
  logic chip_tick_r; // Registered tick
  logic in_payload_r; // Between sync match and frame end
  logic have_half_r; // First chip of a Manchester pair held
  logic half_r; // Value of that first chip
  logic dec_valid_r; // One decoded payload bit
  logic dec_bit_r; // Its value
  logic nrz_valid_r; // Preamble or sync chip out
  logic nrz_bit_r; // Its value
  logic manch_err_r; // Pair was 00 or 11
  logic [7:0] shift_r; // Byte being assembled, first bit is MSB
  logic [2:0] bit_cnt_r; // Bits in shift_r
  logic byte_valid_r; // Byte strobe
  logic [7:0] byte_data_r; // Byte held for FIFO and register reads
  logic lfsr_bit; // Current whitening mask bit
  logic [8:0] lfsr_state; // Whitening register contents
  logic lfsr_step; // Advance once per processed payload bit
  logic pay_tick; // A payload chip arrives this cycle

  assign cfg.divisor = {rate_hi_r, rate_lo_r};
  assign cfg.line_code_select = pkt1_r[RDF_LCS_LSB+1:RDF_LCS_LSB];
  // Select 11 (both methods) decodes as pass; decode gives one treatment
  assign mode = rdf_decode(cfg.line_code_select, data_mode);

  // Register writes; writes to the FIFO port are ignored in a receiver
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rate_hi_r <= RDF_RST_RATE_HI;
      rate_lo_r <= RDF_RST_RATE_LO;
      pkt1_r <= RDF_RST_PKT1;
    end else if (reg_wr) begin
      unique case (reg_addr)
        RDF_OFS_RATE_HI: rate_hi_r <= reg_wdata;
        RDF_OFS_RATE_LO: rate_lo_r <= reg_wdata;
        RDF_OFS_PKT1: pkt1_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Register reads, one cycle late; unmapped offsets read zero
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        RDF_OFS_FIFO: reg_rdata_r <= byte_data_r;
        RDF_OFS_RATE_HI: reg_rdata_r <= rate_hi_r;
        RDF_OFS_RATE_LO: reg_rdata_r <= rate_lo_r;
        RDF_OFS_PKT1: reg_rdata_r <= pkt1_r;
        default: reg_rdata_r <= 8'h00;
      endcase
    end
  end

  // Chip period: same divisor for preamble, sync, payload and CRC; zero acts as one
  assign div_last = (cfg.divisor == 16'h0000) ? 16'h0000 : cfg.divisor - 16'h0001;
  assign tick = (div_cnt_r >= div_last);
  assign pay_tick = tick && in_payload_r;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt_r <= 16'h0000;
      chip_tick_r <= 1'b0;
    end else begin
      div_cnt_r <= tick ? 16'h0000 : div_cnt_r + 16'h0001;
      chip_tick_r <= tick;
    end
  end

  // Payload window: opened by sync match, closed by frame end
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      in_payload_r <= 1'b0;
    end else if (sync_match) begin
      in_payload_r <= 1'b1;
    end else if (frame_end) begin
      in_payload_r <= 1'b0;
    end
  end

  // Preamble and sync chips leave as NRZ bits, never decoded
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      nrz_valid_r <= 1'b0;
      nrz_bit_r <= 1'b0;
    end else begin
      nrz_valid_r <= tick && !in_payload_r;
      if (tick && !in_payload_r) begin
        nrz_bit_r <= chip_in;
      end
    end
  end

  // Manchester pair tracking; a new frame always starts on a pair boundary
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      have_half_r <= 1'b0;
      half_r <= 1'b0;
    end else if (sync_match || frame_end || mode != RDF_MANCH) begin
      have_half_r <= 1'b0;
    end else if (pay_tick) begin
      have_half_r <= !have_half_r;
      if (!have_half_r) begin
        half_r <= chip_in;
      end
    end
  end

  assign lfsr_step = pay_tick && mode == RDF_WHITEN;

  // Bit decode: pair to bit, XOR with sequence, or pass untouched
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dec_valid_r <= 1'b0;
      dec_bit_r <= 1'b0;
      manch_err_r <= 1'b0;
    end else begin
      dec_valid_r <= 1'b0;
      manch_err_r <= 1'b0;
      if (pay_tick) begin
        unique case (mode)
          RDF_MANCH: begin
            // Second chip completes the pair; 10 -> 1, 01 -> 0
            if (have_half_r) begin
              dec_valid_r <= 1'b1;
              dec_bit_r <= half_r;
              manch_err_r <= (half_r == chip_in);
            end
          end
          RDF_WHITEN: begin
            dec_valid_r <= 1'b1;
            dec_bit_r <= chip_in ^ lfsr_bit;
          end
          RDF_PASS: begin
            dec_valid_r <= 1'b1;
            dec_bit_r <= chip_in;
          end
        endcase
      end
    end
  end

  // Byte packing; only restored bits ever reach the FIFO side
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_r <= 8'h00;
      bit_cnt_r <= 3'h0;
      byte_valid_r <= 1'b0;
      byte_data_r <= 8'h00;
    end else begin
      byte_valid_r <= 1'b0;
      if (sync_match) begin
        bit_cnt_r <= 3'h0;
      end else if (dec_valid_r) begin
        shift_r <= {shift_r[6:0], dec_bit_r};
        bit_cnt_r <= bit_cnt_r + 3'h1;
        if (bit_cnt_r == RDF_BIT_LAST) begin
          byte_valid_r <= 1'b1;
          byte_data_r <= {shift_r[6:0], dec_bit_r};
        end
      end
    end
  end

  // Whitening sequence, preset on each sync match
  rdf_whiten_lfsr #(.WIDTH(9)) u_lfsr (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .preset(sync_match),
    .step(lfsr_step),
    .seq_bit(lfsr_bit),
    .state(lfsr_state)
  );

  assign reg_rdata = reg_rdata_r;
  assign chip_tick = chip_tick_r;
  assign nrz_valid = nrz_valid_r;
  assign nrz_bit = nrz_bit_r;
  assign byte_valid = byte_valid_r;
  assign byte_data = byte_data_r;
  assign manch_error = manch_err_r;

  // Checks
  sequence s_first_chip;
    pay_tick && mode == RDF_MANCH && !have_half_r && !sync_match && !frame_end;
  endsequence
  sequence s_second_chip;
    pay_tick && mode == RDF_MANCH && have_half_r && !sync_match && !frame_end;
  endsequence

  property p_cont_no_manch;
    @(posedge sys_clk) disable iff (!arst_n)
      (pay_tick && data_mode != RDF_DMODE_PACKET) |=> dec_valid_r;
  endproperty
  a_cont_no_manch: assert property (p_cont_no_manch) else $error("continuous mode lost a bit");

  property p_manch_value;
    @(posedge sys_clk) disable iff (!arst_n)
      s_second_chip |=> dec_valid_r && dec_bit_r == $past(half_r, 1)
        && (manch_err_r || dec_bit_r != $past(chip_in));
  endproperty
  a_manch_value: assert property (p_manch_value) else $error("manchester bit wrong");

  property p_half_rate;
    @(posedge sys_clk) disable iff (!arst_n)
      s_first_chip ##1 (!pay_tick) [*1] |-> !dec_valid_r;
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("bit after first chip");

  property p_preamble_nrz;
    @(posedge sys_clk) disable iff (!arst_n)
      (tick && !in_payload_r) |=> nrz_valid_r && nrz_bit_r == $past(chip_in) && !dec_valid_r;
  endproperty
  a_preamble_nrz: assert property (p_preamble_nrz) else $error("sync chip not passed");

  // Divisor four is the rate the bench uses first; it must hold over the whole period
  property p_chip_period;
    @(posedge sys_clk) disable iff (!arst_n)
      (tick && cfg.divisor == 16'h0004) ##1 (cfg.divisor == 16'h0004) [*4]
        |-> tick && !$past(tick, 1) && !$past(tick, 2) && !$past(tick, 3);
  endproperty
  a_chip_period: assert property (p_chip_period) else $error("chip period wrong");

  property p_byte_eight;
    @(posedge sys_clk) disable iff (!arst_n)
      byte_valid_r |-> $past(dec_valid_r) && $past(bit_cnt_r) == RDF_BIT_LAST
        && byte_data_r[0] == $past(dec_bit_r);
  endproperty
  a_byte_eight: assert property (p_byte_eight) else $error("byte not from 8 bits");

  property p_dewhiten;
    @(posedge sys_clk) disable iff (!arst_n)
      (pay_tick && mode == RDF_WHITEN) |=> dec_bit_r == ($past(chip_in) ^ $past(lfsr_bit));
  endproperty
  a_dewhiten: assert property (p_dewhiten) else $error("de-whitening wrong");

  property p_lfsr_preset;
    @(posedge sys_clk) disable iff (!arst_n)
      sync_match |=> lfsr_state == RDF_LFSR_PRESET;
  endproperty
  a_lfsr_preset: assert property (p_lfsr_preset) else $error("lfsr not preset");

  property p_pass;
    @(posedge sys_clk) disable iff (!arst_n)
      (pay_tick && mode == RDF_PASS) |=> dec_valid_r && dec_bit_r == $past(chip_in);
  endproperty
  a_pass: assert property (p_pass) else $error("pass mode altered data");
endmodule
`default_nettype wire

// ---- rdf_chip_source.sv ----
// Far-side chip source standing in for the demodulator and packet framer
`timescale 1ns/1ns
`default_nettype none
module rdf_chip_source (
  // Clock and chip timing from the decoder
  input wire logic sys_clk,
  input wire logic chip_tick,
  // Chip stream and framing pulses
  output logic chip_in,
  output logic sync_match,
  output logic frame_end
);
  // Idle levels until the first frame
  initial begin
    chip_in = 1'b0;
    sync_match = 1'b0;
    frame_end = 1'b0;
  end

  // Present the next chip just after the previous one was taken
  // Framing pulses sit between two sampling edges, so they never share one
  task automatic send_chip(input logic c, input logic sm, input logic fe);
    @(posedge sys_clk);
    #1;
    // Pulses drop on the first idle edge; each signal is set once per time step
    while (chip_tick !== 1'b1) begin
      sync_match = 1'b0;
      frame_end = 1'b0;
      @(posedge sys_clk);
      #1;
    end
    chip_in = c;
    sync_match = sm;
    frame_end = fe;
  endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the receive DC-free decoder
`timescale 1ns/1ns
`default_nettype none
module testbench import rdf_pkg::*; ();
  // Design connections
  logic sys_clk;
  logic arst_n;
  logic [6:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [1:0] data_mode;
  logic chip_in;
  logic sync_match;
  logic frame_end;
  logic chip_tick;
  logic nrz_valid;
  logic nrz_bit;
  logic byte_valid;
  logic [7:0] byte_data;
  logic manch_error;
  // Bookkeeping
  int n_fail = 0;
  int checks = 0;
  int seed = 87935;
  int cyc = 0;
  int last_tick = 0;
  int n_err = 0;
  int div = 4;
  bit in_pay = 0;
  logic [7:0] got_q[$];
  logic nrz_q[$];
  // Frame table, one select setting at a time, every select code and two continuous modes
  logic [1:0] sel_t[6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1, 2'h2};
  logic [1:0] dm_t[6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h3};

  rdf_rx_dc_free_decoder u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .data_mode(data_mode), .chip_in(chip_in), .sync_match(sync_match),
    .frame_end(frame_end), .chip_tick(chip_tick), .nrz_valid(nrz_valid),
    .nrz_bit(nrz_bit), .byte_valid(byte_valid), .byte_data(byte_data),
    .manch_error(manch_error));

  rdf_chip_source u_src (.sys_clk(sys_clk), .chip_tick(chip_tick), .chip_in(chip_in),
    .sync_match(sync_match), .frame_end(frame_end));

  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_cnt(input int got, input int exp);
    checks++;
    if (got != exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One register cycle; a read compares against d
  task automatic reg_acc(input bit wr, input logic [6:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = wr;
    reg_rd = !wr;
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    if (!wr) cmp_byte(reg_rdata, d);
  endtask

  // Collect pulses; each one-cycle pulse is seen once at the following edge
  always @(posedge sys_clk) begin
    cyc++;
    if (byte_valid === 1'b1) got_q.push_back(byte_data);
    if (nrz_valid === 1'b1) nrz_q.push_back(nrz_bit);
    if (manch_error === 1'b1) n_err++;
    if (chip_tick === 1'b1) begin
      if (in_pay) cmp_cnt(cyc - last_tick, div);
      last_tick = cyc;
    end
  end

  // Preamble/sync chips, encoded payload, trailing chips; then compare all
  task automatic run_frame(input logic [1:0] sel, input logic [1:0] dm, input int nby,
    input bit bad);
    logic [7:0] dat[$];
    logic ch[$];
    logic ex_q[$];
    logic [8:0] lf;
    logic [7:0] d;
    bit man;
    bit wht;
    // Divisor only grows between frames so the chip counter never overshoots
    reg_acc(1'b1, RDF_OFS_RATE_LO, 8'(div));
    reg_acc(1'b1, RDF_OFS_PKT1, {1'b0, sel, 5'h10});
    reg_acc(1'b0, RDF_OFS_PKT1, {1'b0, sel, 5'h10});
    data_mode = dm;
    man = sel == RDF_LCS_MANCH && dm == RDF_DMODE_PACKET;
    wht = sel == RDF_LCS_WHITEN;
    lf = RDF_LFSR_PRESET;
    for (int i = 0; i < nby; i++) begin
      d = 8'($random(seed));
      dat.push_back(d);
      for (int b = 7; b >= 0; b--) begin
        if (man) begin
          ch.push_back(d[b]);
          ch.push_back(~d[b]);
        end else begin
          ch.push_back(d[b] ^ (wht & lf[0]));
          if (wht) lf = {lf[0] ^ lf[5], lf[8:1]};
        end
      end
    end
    // Broken pair keeps its first chip, so the decoded byte is unchanged
    if (bad) ch[1] = ~ch[1];
    for (int i = 0; i < 12; i++) ex_q.push_back(1'($random(seed)));
    foreach (ex_q[i]) begin
      if (i == 8) begin
        foreach (ch[j]) begin
          u_src.send_chip(ch[j], j == 0, 1'b0);
          in_pay = j > 1;
        end
        in_pay = 0;
      end
      u_src.send_chip(ex_q[i], 1'b0, i == 8);
      if (i == 0) begin
        // The stale chip taken just before this one is reported at the next edge
        @(posedge sys_clk);
        #1;
        got_q.delete();
        nrz_q.delete();
        n_err = 0;
      end
    end
    for (int k = 0; k < 200 && nrz_q.size() < 12; k++) @(posedge sys_clk);
    repeat (2) @(posedge sys_clk);
    cmp_cnt(nrz_q.size(), 12);
    foreach (nrz_q[i]) cmp_byte({7'h00, nrz_q[i]}, {7'h00, ex_q[i]});
    cmp_cnt(got_q.size(), nby);
    foreach (got_q[i]) cmp_byte(got_q[i], dat[i]);
    cmp_cnt(n_err, int'(bad));
    reg_acc(1'b0, RDF_OFS_FIFO, dat[nby - 1]);
  endtask

  task automatic end_of_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    arst_n = 1'b0;
    reg_addr = 7'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    data_mode = 2'h0;
    repeat (8) @(posedge sys_clk);
    #1;
    arst_n = 1'b1;
    reg_acc(1'b0, RDF_OFS_RATE_HI, RDF_RST_RATE_HI);
    reg_acc(1'b0, RDF_OFS_RATE_LO, RDF_RST_RATE_LO);
    reg_acc(1'b1, RDF_OFS_RATE_HI, 8'h00);
    reg_acc(1'b0, RDF_OFS_PKT1, RDF_RST_PKT1);
    reg_acc(1'b1, RDF_OFS_FIFO, 8'h5a);
    reg_acc(1'b0, RDF_OFS_FIFO, 8'h00);
    reg_acc(1'b0, 7'h05, 8'h00);
    // Shrink the divisor just after a chip so the counter is below it
    for (int k = 0; k < 40 && chip_tick !== 1'b1; k++) @(posedge sys_clk);
    for (int f = 0; f < 6; f++) begin
      div = 4 + f / 2;
      run_frame(sel_t[f], dm_t[f], 2 + ($random(seed) & 1), f == 1);
    end
    end_of_test();
  end

  // Watchdog: the frames need under two thousand cycles in all; twenty thousand is ample
  initial begin
    #200000;
    n_fail++;
    end_of_test();
  end
endmodule
`default_nettype wire
